// ### design/ufbc_core.sv
`timescale 1ns/10ps
`default_nettype none
module ufbc_core import ufbc_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire ufbc_io_req_t io_req,
    output logic [7:0] io_rdata,
    input wire logic rxd_pin,
    output logic txd_out,
    output logic txd_oe,
    output logic sync_serial_clock_out,
    output logic sync_serial_clock_oe
);
    typedef struct packed {
        ufbc_frame_cfg_t cfg;
        logic sel;
        logic [3:0] baud_hi;
        logic [7:0] baud_lo;
        logic reload;
        logic double_speed;
        logic mpcm;
        logic [2:0] irq_en;
        logic rx_en;
        logic tx_en;
        logic char_size_high;
        logic tx_ninth_bit;
        logic tx_empty;
        logic tx_done;
        logic [8:0] tx_hold;
        ufbc_tx_st_t tx_st;
        logic [8:0] tx_data;
        logic [3:0] tx_idx;
        logic tx_par;
        logic [3:0] tx_os;
        logic txd;
        ufbc_rx_st_t rx_st;
        logic [8:0] rx_data;
        logic [3:0] rx_idx;
        logic rx_par;
        logic rx_pe;
        logic [3:0] rx_os;
        logic overrun;
        logic sync_serial_clock;
        logic sync1;
        logic sync2;
        logic [7:0] rdata;
    } ufbc_core_st_t;

    ufbc_core_st_t s;
    ufbc_core_st_t next_s;
    logic tick;
    logic fifo_in_valid;
    logic fifo_in_ready;
    ufbc_rx_word_t fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    ufbc_rx_word_t fifo_out_data;
    logic [7:0] off;
    logic hit;
    logic [3:0] nbits;
    logic [3:0] osr_last;
    logic tx_step;
    logic rx_step;
    logic tx_edge;
    logic rx_edge;
    logic rxd;
    logic [3:0] tx_next_idx;

    // ----------------------------------------------------------------
    // baud prescaler and receive buffer
    // ----------------------------------------------------------------
    ufbc_baud #(.WIDTH(BAUD_WIDTH)) u_baud (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .setting({s.baud_hi, s.baud_lo}),
        .reload(s.reload),
        .tick(tick)
    );

    ufbc_fifo2 #(.WIDTH($bits(ufbc_rx_word_t)), .DEPTH(2)) u_rx_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ----------------------------------------------------------------
    // decode and bit timing
    // ----------------------------------------------------------------
    always_comb begin
        off = io_req.data_space ? io_req.addr - DATA_SPACE_BASE : io_req.addr;
        hit = io_req.data_space ? (io_req.addr >= DATA_SPACE_BASE && io_req.addr <= DATA_SPACE_TOP)
                                : (io_req.addr <= IO_TOP);
    end

    assign nbits = ufbc_char_bits({s.char_size_high, s.cfg.char_size_mid, s.cfg.char_size_low});
    assign osr_last = s.double_speed ? OSR_DOUBLE_LAST : OSR_NORMAL_LAST;
    assign tx_edge = tick && (s.sync_serial_clock == s.cfg.clock_polarity);
    assign rx_edge = tick && (s.sync_serial_clock != s.cfg.clock_polarity);
    assign tx_step = s.cfg.sync_mode_select ? tx_edge : (tick && s.tx_os == osr_last);
    assign rx_step = s.cfg.sync_mode_select ? rx_edge : (tick && s.rx_os == osr_last);
    assign rxd = s.sync2;
    assign tx_next_idx = s.tx_idx + 4'h1;
    assign fifo_in_valid = (s.rx_st == RX_STOP) && rx_step;
    assign fifo_in_data = '{data: s.rx_data, frame_err: !rxd, parity_err: s.rx_pe};
    assign fifo_out_ready = io_req.rd && hit && (off == OFS_DATA_BUFFER);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.sync1 = rxd_pin;
        next_s.sync2 = s.sync1;
        next_s.reload = 1'b0;
        // register writes
        if (io_req.wr && hit) begin
            case (off)
                OFS_SHARED: begin
                    next_s.sel = io_req.wdata[REG_SELECT_BIT];
                    if (io_req.wdata[REG_SELECT_BIT]) begin
                        next_s.cfg = io_req.wdata[6:0];
                    end else begin
                        next_s.baud_hi = io_req.wdata[3:0];
                    end
                end
                OFS_BAUD_LOW: begin
                    next_s.baud_lo = io_req.wdata;
                    next_s.reload = 1'b1;
                end
                OFS_CTRL_STAT_A: begin
                    if (io_req.wdata[CSA_TX_DONE_BIT]) begin
                        next_s.tx_done = 1'b0;
                    end
                    next_s.double_speed = io_req.wdata[1];
                    next_s.mpcm = io_req.wdata[0];
                end
                OFS_CTRL_B: begin
                    next_s.irq_en = io_req.wdata[7:5];
                    next_s.rx_en = io_req.wdata[4];
                    next_s.tx_en = io_req.wdata[3];
                    next_s.char_size_high = io_req.wdata[2];
                    next_s.tx_ninth_bit = io_req.wdata[0];
                end
                OFS_DATA_BUFFER: begin
                    if (s.tx_empty) begin
                        next_s.tx_hold = {s.tx_ninth_bit, io_req.wdata};
                        next_s.tx_empty = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // register reads
        next_s.rdata = 8'h00;
        if (io_req.rd && hit) begin
            case (off)
                OFS_SHARED: next_s.rdata = s.sel ? {1'b1, s.cfg} : {4'h0, s.baud_hi};
                OFS_BAUD_LOW: next_s.rdata = s.baud_lo;
                OFS_CTRL_STAT_A: next_s.rdata = {fifo_out_valid, s.tx_done, s.tx_empty,
                    fifo_out_valid && fifo_out_data.frame_err, s.overrun,
                    fifo_out_valid && fifo_out_data.parity_err, s.double_speed, s.mpcm};
                OFS_CTRL_B: next_s.rdata = {s.irq_en, s.rx_en, s.tx_en, s.char_size_high,
                    fifo_out_valid && fifo_out_data.data[8], s.tx_ninth_bit};
                OFS_DATA_BUFFER: begin
                    next_s.rdata = fifo_out_data.data[7:0];
                    next_s.overrun = 1'b0;
                end
                default: next_s.rdata = 8'h00;
            endcase
        end
        // serial clock
        if (s.cfg.sync_mode_select) begin
            next_s.sync_serial_clock = tick ? ~s.sync_serial_clock : s.sync_serial_clock;
        end else begin
            next_s.sync_serial_clock = s.cfg.clock_polarity;
        end
        if (tick) begin
            next_s.tx_os = (s.tx_os == osr_last) ? 4'h0 : s.tx_os + 4'h1;
        end
        // transmitter
        if (tx_step) begin
            case (s.tx_st)
                TX_IDLE: begin
                    if (s.tx_en && !s.tx_empty) begin
                        next_s.tx_data = s.tx_hold;
                        next_s.tx_empty = 1'b1;
                        next_s.txd = 1'b0;
                        next_s.tx_st = TX_START;
                    end
                end
                TX_START: begin
                    next_s.txd = s.tx_data[0];
                    next_s.tx_par = s.tx_data[0];
                    next_s.tx_idx = 4'h0;
                    next_s.tx_st = TX_DATA;
                end
                TX_DATA: begin
                    if (s.tx_idx == nbits - 4'h1) begin
                        if (s.cfg.parity_enable_bit) begin
                            next_s.txd = s.tx_par ^ s.cfg.parity_odd_bit;
                            next_s.tx_st = TX_PAR;
                        end else begin
                            next_s.txd = 1'b1;
                            next_s.tx_st = TX_STOP1;
                        end
                    end else begin
                        next_s.tx_idx = tx_next_idx;
                        next_s.txd = s.tx_data[tx_next_idx];
                        next_s.tx_par = s.tx_par ^ s.tx_data[tx_next_idx];
                    end
                end
                TX_PAR: begin
                    next_s.txd = 1'b1;
                    next_s.tx_st = TX_STOP1;
                end
                TX_STOP1: begin
                    next_s.tx_st = s.cfg.stop_bits_select ? TX_STOP2 : TX_IDLE;
                    next_s.tx_done = next_s.tx_done || (!s.cfg.stop_bits_select && s.tx_empty);
                end
                TX_STOP2: begin
                    next_s.tx_st = TX_IDLE;
                    next_s.tx_done = next_s.tx_done || s.tx_empty;
                end
                default: next_s.tx_st = TX_IDLE;
            endcase
        end
        // receiver
        if (!s.cfg.sync_mode_select && tick && s.rx_st != RX_IDLE) begin
            next_s.rx_os = (s.rx_os == osr_last) ? 4'h0 : s.rx_os + 4'h1;
        end
        case (s.rx_st)
            RX_IDLE: begin
                next_s.rx_os = 4'h0;
                next_s.rx_data = 9'h000;
                next_s.rx_idx = 4'h0;
                next_s.rx_par = 1'b0;
                next_s.rx_pe = 1'b0;
                if (s.rx_en && !rxd) begin
                    if (!s.cfg.sync_mode_select) begin
                        next_s.rx_st = RX_START;
                    end else if (rx_edge) begin
                        next_s.rx_st = RX_DATA;
                    end
                end
            end
            RX_START: begin
                if (tick && s.rx_os == (osr_last >> 1)) begin
                    next_s.rx_os = 4'h0;
                    next_s.rx_st = rxd ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_step) begin
                    next_s.rx_data[s.rx_idx] = rxd;
                    next_s.rx_par = s.rx_par ^ rxd;
                    next_s.rx_idx = s.rx_idx + 4'h1;
                    if (s.rx_idx == nbits - 4'h1) begin
                        next_s.rx_st = s.cfg.parity_enable_bit ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (rx_step) begin
                    next_s.rx_pe = s.rx_par ^ rxd ^ s.cfg.parity_odd_bit;
                    next_s.rx_st = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_step) begin
                    next_s.rx_st = RX_IDLE;
                    if (!fifo_in_ready) begin
                        next_s.overrun = 1'b1;
                    end
                end
            end
            default: next_s.rx_st = RX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.cfg <= FFC_RESET;
            s.sel <= 1'b1;
            s.tx_empty <= CSA_RESET[5];
            s.txd <= 1'b1;
            s.sync1 <= 1'b1;
            s.sync2 <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign io_rdata = s.rdata;
    assign txd_out = s.txd;
    assign txd_oe = s.tx_en || (s.tx_st != TX_IDLE);
    assign sync_serial_clock_out = s.sync_serial_clock;
    assign sync_serial_clock_oe = s.cfg.sync_mode_select;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb_main @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    property p_shared_write;
        io_req.wr && hit && off == OFS_SHARED |=>
            (($past(io_req.wdata[7]) && s.cfg == $past(io_req.wdata[6:0]) && s.sel)
            || (!$past(io_req.wdata[7]) && s.baud_hi == $past(io_req.wdata[3:0]) && !s.sel));
    endproperty
    a_shared_write: assert property (p_shared_write)
        else $error("shared location write landed in wrong register");

    property p_shared_read;
        io_req.rd && hit && off == OFS_SHARED && !io_req.wr |=> io_rdata[7] == $past(s.sel);
    endproperty
    a_shared_read: assert property (p_shared_read)
        else $error("register select bit reads wrong");

    property p_baud_hi_zero;
        io_req.rd && hit && off == OFS_SHARED && !s.sel |=> io_rdata[7:4] == 4'h0;
    endproperty
    a_baud_hi_zero: assert property (p_baud_hi_zero)
        else $error("unused baud high bits not zero");

    property p_low_reload;
        io_req.wr && hit && off == OFS_BAUD_LOW |=> s.reload
            ##1 (!tick || $past({s.baud_hi, s.baud_lo}) == 12'h000);
    endproperty
    a_low_reload: assert property (p_low_reload)
        else $error("baud low write did not reload prescaler");

    property p_reset_values;
        disable iff (1'b0)
        !rst_b |-> s.cfg == FFC_RESET && {s.baud_hi, s.baud_lo} == 12'h000;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("wrong configuration under reset");

    property p_sync_edge;
        s.cfg.sync_mode_select && $stable(s.cfg) && $changed(txd_out) |->
            $changed(sync_serial_clock_out) && sync_serial_clock_out != s.cfg.clock_polarity;
    endproperty
    a_sync_edge: assert property (p_sync_edge)
        else $error("transmit data changed on wrong clock edge");

    property p_one_stop;
        s.tx_st == TX_STOP1 && tx_step && !s.cfg.stop_bits_select |=> s.tx_st == TX_IDLE;
    endproperty
    a_one_stop: assert property (p_one_stop)
        else $error("extra stop bit sent");

    property p_rx_upper_zero;
        fifo_in_valid |-> (fifo_in_data.data >> nbits) == 9'h000;
    endproperty
    a_rx_upper_zero: assert property (p_rx_upper_zero)
        else $error("unused received bits not zero");

    property p_parity_bit;
        s.tx_st == TX_DATA && tx_step && s.tx_idx == nbits - 4'h1 && s.cfg.parity_enable_bit
            |=> txd_out == ($past(s.tx_par) ^ s.cfg.parity_odd_bit);
    endproperty
    a_parity_bit: assert property (p_parity_bit)
        else $error("parity bit value wrong");

    c_parity_frame: cover property (s.tx_st == TX_PAR ##[1:400] s.tx_st == TX_IDLE);
    c_rx_push: cover property (fifo_in_valid && fifo_in_ready);
    c_overrun: cover property (fifo_in_valid && !fifo_in_ready);
    c_sync_mode: cover property (s.cfg.sync_mode_select && tx_edge && s.tx_st == TX_DATA);
endmodule
`default_nettype wire

// ### design/ufbc_pkg.sv
// Behaviour
// - shared location write: bit 7 set updates frame control, clear updates baud high.
// - shared location reads bit 7 as one for frame control, zero for baud high.
// - mode select 0 is asynchronous, 1 is synchronous clocked operation.
// - parity field 00 off, 01 reserved, 10 even, 11 odd, both directions.
// - transmitter inserts computed parity into every frame when enabled.
// - receiver checks parity and flags a parity error on mismatch.
// - stop select 0 sends one stop bit, 1 sends two; receiver ignores it.
// - three-bit size code gives 5, 6, 7, 8 or 9 data bits.
// - sync polarity 0: transmit on rising, sample on falling; 1 swaps.
// - baud setting is 12 bits: four high bits, eight low bits.
// - writing baud low reloads the prescaler with the full setting at once.
// - reset gives async, no parity, one stop, 8 bits, polarity 0, baud 0.
// - registers sit at I/O offsets 0x00-0x3F and at offset plus 0x20.
// - double speed in async mode cuts the divider from 16 to 8.
// - short characters: unused transmit bits ignored, received ones read zero.
package ufbc_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_BAUD_LOW = 8'h09;
    localparam logic [7:0] OFS_CTRL_B = 8'h0A;
    localparam logic [7:0] OFS_CTRL_STAT_A = 8'h0B;
    localparam logic [7:0] OFS_DATA_BUFFER = 8'h0C;
    localparam logic [7:0] OFS_SHARED = 8'h20;
    localparam logic [7:0] IO_TOP = 8'h3F;
    localparam logic [7:0] DATA_SPACE_BASE = 8'h20;
    localparam logic [7:0] DATA_SPACE_TOP = 8'h5F;
    localparam int REG_SELECT_BIT = 7;
    localparam int CSA_TX_DONE_BIT = 6;
    localparam logic [7:0] CSA_RESET = 8'h20;
    localparam logic [3:0] OSR_NORMAL_LAST = 4'hF;
    localparam logic [3:0] OSR_DOUBLE_LAST = 4'h7;
    localparam int BAUD_WIDTH = 12;

    typedef struct packed {
        logic sync_mode_select;
        logic parity_enable_bit;
        logic parity_odd_bit;
        logic stop_bits_select;
        logic char_size_mid;
        logic char_size_low;
        logic clock_polarity;
    } ufbc_frame_cfg_t;

    localparam ufbc_frame_cfg_t FFC_RESET = 7'h06;

    typedef struct packed {
        logic wr;
        logic rd;
        logic data_space;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ufbc_io_req_t;

    typedef struct packed {
        logic [8:0] data;
        logic frame_err;
        logic parity_err;
    } ufbc_rx_word_t;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} ufbc_tx_st_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufbc_rx_st_t;

    function automatic logic [3:0] ufbc_char_bits(input logic [2:0] code);
        case (code)
            3'h0: ufbc_char_bits = 4'h5;
            3'h1: ufbc_char_bits = 4'h6;
            3'h2: ufbc_char_bits = 4'h7;
            3'h7: ufbc_char_bits = 4'h9;
            default: ufbc_char_bits = 4'h8;
        endcase
    endfunction
endpackage

// ### design/ufbc_baud.sv
`timescale 1ns/10ps
`default_nettype none
module ufbc_baud import ufbc_pkg::*; #(
    parameter int WIDTH = BAUD_WIDTH
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] setting,
    input wire logic reload,
    output logic tick
);
    if (WIDTH < 1 || WIDTH > 16) begin
        $error("ufbc_baud: width out of range");
    end

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } ufbc_baud_st_t;

    ufbc_baud_st_t s;
    ufbc_baud_st_t next_s;

    // ----------------------------------------------------------------
    // prescaler: tick once every setting plus one clocks
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        if (reload) begin
            next_s.cnt = setting;
        end else if (s.cnt == '0) begin
            next_s.cnt = setting;
        end else begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = (s.cnt == '0) && !reload;

    property p_reload_restarts;
        @(posedge ref_clk) disable iff (!rst_b)
        reload |=> (s.cnt == $past(setting)) && (!tick || $past(setting) == '0);
    endproperty
    a_reload_restarts: assert property (p_reload_restarts)
        else $error("prescaler not reloaded after baud write");
endmodule
`default_nettype wire

// ### design/ufbc_fifo2.sv
`timescale 1ns/10ps
`default_nettype none
module ufbc_fifo2 #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 2
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    if (DEPTH != 2 || WIDTH < 1) begin
        $error("ufbc_fifo2: only two entries supported");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
    } ufbc_fifo_st_t;

    ufbc_fifo_st_t s;
    ufbc_fifo_st_t next_s;
    logic push;
    logic pop;

    // ----------------------------------------------------------------
    // two-entry store
    // ----------------------------------------------------------------
    assign in_ready = (s.count != 2'h2);
    assign out_valid = (s.count != 2'h0);
    assign out_data = s.mem[s.rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wr_ptr] = in_data;
            next_s.wr_ptr = ~s.wr_ptr;
        end
        if (pop) begin
            next_s.rd_ptr = ~s.rd_ptr;
        end
        next_s.count = s.count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

// ### test/ufbc_remote.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// remote serial transceiver
// ----------------------------------------
module ufbc_remote (
    input wire logic ref_clk,
    input wire logic txd,
    output logic rxd
);
    initial rxd = 1'b1;
    // low start, bits lsb first, then idle high
    task automatic send(input logic [10:0] bits, input int n, input int per);
        rxd <= 1'b0;
        repeat (per) @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            rxd <= bits[i];
            repeat (per) @(posedge ref_clk);
        end
        rxd <= 1'b1;
        repeat (2 * per) @(posedge ref_clk);
    endtask
    // samples mid-bit after the start edge
    task automatic take(input int per, output logic [11:0] got);
        int w;
        w = 0;
        while (txd !== 1'b0 && w < 5000) begin
            @(posedge ref_clk);
            w++;
        end
        repeat (per / 2) @(posedge ref_clk);
        for (int i = 0; i < 12; i++) begin
            got[i] = txd;
            repeat (per) @(posedge ref_clk);
        end
    endtask
endmodule
`default_nettype wire

// ### test/tb_usart_frame_baud_config.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module tb_usart_frame_baud_config import ufbc_pkg::*;;
    logic ref_clk;
    logic rst_b;
    ufbc_io_req_t req;
    logic [7:0] io_rdata;
    logic [7:0] rv;
    logic [11:0] got;
    wire logic rxd;
    wire logic txd;
    wire logic txd_oe;
    wire logic sclk;
    wire logic sclk_oe;
    int bad_count;
    int comparisons;
    ufbc_core uut (.ref_clk(ref_clk), .rst_b(rst_b), .io_req(req), .io_rdata(io_rdata),
        .rxd_pin(rxd), .txd_out(txd), .txd_oe(txd_oe), .sync_serial_clock_out(sclk),
        .sync_serial_clock_oe(sclk_oe));
    ufbc_remote rem (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic acc(input logic w, input logic ds, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        req = '{wr: w, rd: !w, data_space: ds, addr: a, wdata: d};
        @(posedge ref_clk);
        #1;
        req.wr = 1'b0;
        req.rd = 1'b0;
        rv = io_rdata;
    endtask
    task automatic rchk(input logic ds, input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, ds, a, 8'h00);
        `CHK("read", e, rv)
    endtask
    task automatic results;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----------------------------------------
    // clock, reset, watchdog
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        bad_count++;
        results();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        bad_count = 0;
        comparisons = 0;
        req = '0;
        rst_b = 1'b1;
        #1;
        rst_b = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        rchk(1'b0, 8'h20, 8'h86);
        rchk(1'b0, 8'h09, 8'h00);
        rchk(1'b0, 8'h0B, 8'h20);
        acc(1'b1, 1'b0, 8'h20, 8'h7F);
        rchk(1'b0, 8'h20, 8'h0F);
        acc(1'b1, 1'b1, 8'h40, 8'h00);
        rchk(1'b0, 8'h20, 8'h00);
        acc(1'b1, 1'b1, 8'h29, 8'h01);
        rchk(1'b0, 8'h09, 8'h01);
        acc(1'b1, 1'b0, 8'h20, 8'hC6);
        `CHK("clock_oe", 1'b1, sclk_oe)
        rchk(1'b1, 8'h40, 8'hC6);
        acc(1'b1, 1'b0, 8'h20, 8'hB6);
        `CHK("clock_oe", 1'b0, sclk_oe)
        acc(1'b1, 1'b0, 8'h0A, 8'h08);
        `CHK("txd_oe", 1'b1, txd_oe)
        fork
            rem.take(32, got);
            acc(1'b1, 1'b0, 8'h0C, 8'h35);
        join
        `CHK("tx_frame", {2'b11, 8'h35, 1'b0}, got[10:0])
        acc(1'b1, 1'b0, 8'h20, 8'hC6);
        fork
            rem.take(4, got);
            acc(1'b1, 1'b0, 8'h0C, 8'hA5);
        join
        `CHK("sync_frame", {2'b11, 8'hA5, 1'b0}, got[10:0])
        acc(1'b1, 1'b0, 8'h20, 8'hA6);
        acc(1'b1, 1'b0, 8'h0B, 8'h02);
        `CHK("clock_out", 1'b0, sclk)
        acc(1'b1, 1'b0, 8'h0A, 8'h18);
        rem.send({2'b11, 8'h0F}, 10, 16);
        acc(1'b0, 1'b0, 8'h0B, 8'h00);
        `CHK("status", 8'h84, rv & 8'h84)
        rchk(1'b0, 8'h0C, 8'h0F);
        results();
    end
endmodule
`default_nettype wire
